// ---- rtl/csf_pkg.sv ----
/*
 Package for the processor status flags register: address, field positions,
 reset values and the flag-update operation codes.
 Assumes the core decodes instructions and hands this block an operation code.
*/
package csf_pkg;
   localparam logic [7:0] CSF_ADDR_LO = 8'h03;
   localparam logic [7:0] CSF_ADDR_HI = 8'h83;
   localparam int CSF_BIT_RSV_IND = 7;
   localparam int CSF_BIT_RSV_HIGH = 6;
   localparam int CSF_BIT_BANK = 5;
   localparam int CSF_BIT_WDX = 4;
   localparam int CSF_BIT_SLP = 3;
   localparam int CSF_BIT_Z = 2;
   localparam int CSF_BIT_NC = 1;
   localparam int CSF_BIT_C = 0;
   localparam logic [2:0] CSF_RST_UPPER = 3'h0;
   localparam logic CSF_RST_WDX = 1'b1;
   localparam logic CSF_RST_SLP = 1'b1;
   localparam logic [2:0] CSF_RST_FLAGS = 3'h0;

   typedef enum logic [3:0] {
      CSF_OP_NONE,     // Result flags untouched (move, bit set/clear, swap)
      CSF_OP_ADD,      // Z, nibble carry, carry
      CSF_OP_SUB,      // Z, nibble carry, carry from a + ~b + 1
      CSF_OP_LOGIC,    // Z only
      CSF_OP_CLEAR,    // Result zero, Z set
      CSF_OP_ROR,      // Carry from bit 0
      CSF_OP_ROL       // Carry from bit 7
   } csf_op_t;
endpackage

// ---- rtl/csf_status_reg.sv ----
/*
 Processor status flags register: result flags, reset status bits, bank select.
 Holds the flag-update and write-protect logic for one retiring instruction.
 Assumes the core presents one executed instruction per cycle on i_exec, with
 its operands, result, operation code and optional data-space write, and that
 watchdog and sleep events arrive as single-cycle pulses on this clock.
*/
`timescale 1ns/1ns
`default_nettype none
module csf_status_reg
   import csf_pkg::*;
(
   input wire logic I_REF_CLK,
   input wire logic I_RESET,
   input wire logic i_exec,
   input wire csf_op_t i_op,
   input wire logic [7:0] i_opnd_a,
   input wire logic [7:0] i_opnd_b,
   input wire logic [7:0] i_rot_src,
   input wire logic [7:0] i_result,
   input wire logic i_wr_en,
   input wire logic [7:0] i_wr_addr,
   input wire logic [7:0] i_wr_data,
   input wire logic i_wdog_clear,
   input wire logic i_sleep,
   input wire logic i_wdog_expire,
   input wire logic [6:0] i_direct_addr,
   output logic [7:0] o_status,
   output logic o_bank_select_bit,
   output logic [7:0] o_direct_full_addr
);
   logic [2:0] upper_r;
   logic [2:0] upper_nxt;
   logic watchdog_expired_bit_r;
   logic watchdog_expired_bit_nxt;
   logic sleep_entered_bit_r;
   logic sleep_entered_bit_nxt;
   logic [2:0] flags_r;
   logic [2:0] flags_nxt;

   logic [7:0] status_img;
   logic [8:0] sum;
   logic [4:0] nib;
   logic [7:0] addend;
   logic st_hit;
   logic st_wr;

   logic dec_add;
   logic dec_sub;
   logic dec_arith;
   logic dec_zero_only;
   logic dec_clear;
   logic dec_rot_right;
   logic dec_rot_left;
   logic flag_op;
   logic flags_wr_ok;

   // Either mirror address reaches the one register
   assign st_hit = (i_wr_addr == CSF_ADDR_LO) || (i_wr_addr == CSF_ADDR_HI);
   assign st_wr = i_exec && i_wr_en && st_hit;

   // One strobe per flag-update class
   // Outside a retiring instruction none fires, so idle cycles keep every flag
   always_comb begin
      dec_add = 1'b0;
      dec_sub = 1'b0;
      dec_zero_only = 1'b0;
      dec_clear = 1'b0;
      dec_rot_right = 1'b0;
      dec_rot_left = 1'b0;
      if (i_exec) begin
         case (i_op)
            CSF_OP_ADD: begin
               dec_add = 1'b1;
            end
            CSF_OP_SUB: begin
               dec_sub = 1'b1;
            end
            CSF_OP_LOGIC: begin
               dec_zero_only = 1'b1;
            end
            CSF_OP_CLEAR: begin
               dec_clear = 1'b1;
            end
            CSF_OP_ROR: begin
               dec_rot_right = 1'b1;
            end
            CSF_OP_ROL: begin
               dec_rot_left = 1'b1;
            end
            default: begin
               dec_add = 1'b0;
            end
         endcase
      end
   end
   assign dec_arith = dec_add || dec_sub;
   assign flag_op = dec_arith || dec_zero_only || dec_clear || dec_rot_right || dec_rot_left;
   // A flag-updating instruction locks the data write out of all three flags
   // The upper bits still take the write, so such an instruction can change banks
   assign flags_wr_ok = st_wr && !flag_op;

   // Subtract as add of the two's complement
   assign addend = dec_sub ? ~i_opnd_b : i_opnd_b;
   assign sum = {1'b0, i_opnd_a} + {1'b0, addend} + {8'h00, dec_sub};
   assign nib = {1'b0, i_opnd_a[3:0]} + {1'b0, addend[3:0]} + {4'h0, dec_sub};

   always_comb begin
      flags_nxt = flags_r;
      // Plain write only when no flag update competes
      if (flags_wr_ok) begin
         flags_nxt = i_wr_data[2:0];
      end
      if (dec_arith) begin
         flags_nxt[CSF_BIT_Z] = (sum[7:0] == 8'h00);
         flags_nxt[CSF_BIT_NC] = nib[4];
         flags_nxt[CSF_BIT_C] = sum[8];
      end
      if (dec_zero_only) begin
         flags_nxt[CSF_BIT_Z] = (i_result == 8'h00);
      end
      if (dec_clear) begin
         flags_nxt[CSF_BIT_Z] = 1'b1;
      end
      if (dec_rot_right) begin
         flags_nxt[CSF_BIT_C] = i_rot_src[0];
      end
      if (dec_rot_left) begin
         flags_nxt[CSF_BIT_C] = i_rot_src[7];
      end
   end

   always_comb begin
      upper_nxt = upper_r;
      // Clear-file zeroes the upper bits whatever the data path carries
      if (st_wr && dec_clear) begin
         upper_nxt = 3'h0;
      end else if (st_wr) begin
         upper_nxt = i_wr_data[7:5];
      end
   end

   // Hardware events only; data writes never reach these bits
   // Expiry wins over a same-cycle clear or sleep, so a time-out is never lost
   always_comb begin
      watchdog_expired_bit_nxt = watchdog_expired_bit_r;
      if (i_wdog_expire) begin
         watchdog_expired_bit_nxt = 1'b0;
      end else if (i_wdog_clear || i_sleep) begin
         watchdog_expired_bit_nxt = 1'b1;
      end
   end

   always_comb begin
      sleep_entered_bit_nxt = sleep_entered_bit_r;
      if (i_sleep) begin
         sleep_entered_bit_nxt = 1'b0;
      end else if (i_wdog_clear) begin
         sleep_entered_bit_nxt = 1'b1;
      end
   end

   always_ff @(posedge I_REF_CLK) begin
      if (I_RESET) begin
         flags_r <= CSF_RST_FLAGS;
      end else begin
         flags_r <= flags_nxt;
      end
   end

   always_ff @(posedge I_REF_CLK) begin
      if (I_RESET) begin
         upper_r <= CSF_RST_UPPER;
      end else begin
         upper_r <= upper_nxt;
      end
   end

   always_ff @(posedge I_REF_CLK) begin
      if (I_RESET) begin
         watchdog_expired_bit_r <= CSF_RST_WDX;
      end else begin
         watchdog_expired_bit_r <= watchdog_expired_bit_nxt;
      end
   end

   always_ff @(posedge I_REF_CLK) begin
      if (I_RESET) begin
         sleep_entered_bit_r <= CSF_RST_SLP;
      end else begin
         sleep_entered_bit_r <= sleep_entered_bit_nxt;
      end
   end

   // Image of the register as software reads it at either address
   assign status_img = {upper_r, watchdog_expired_bit_r, sleep_entered_bit_r, flags_r};

   // Registered outputs show the state one edge after any update
   always_ff @(posedge I_REF_CLK) begin
      if (I_RESET) begin
         o_status <= {CSF_RST_UPPER, CSF_RST_WDX, CSF_RST_SLP, CSF_RST_FLAGS};
      end else begin
         o_status <= status_img;
      end
   end

   always_ff @(posedge I_REF_CLK) begin
      if (I_RESET) begin
         o_bank_select_bit <= 1'b0;
      end else begin
         o_bank_select_bit <= upper_r[CSF_BIT_BANK - 5];
      end
   end

   // Bank bit prefixes the seven direct address bits
   always_ff @(posedge I_REF_CLK) begin
      if (I_RESET) begin
         o_direct_full_addr <= 8'h00;
      end else begin
         o_direct_full_addr <= {upper_r[CSF_BIT_BANK - 5], i_direct_addr};
      end
   end
endmodule
`default_nettype wire

// ---- tb/csf_status_chk.sv ----
/* Checker for csf_status_reg, bound to it, sees its ports only.
   Assumes sync active-high reset and at most three edges of update latency. */
`timescale 1ns/1ns
`default_nettype none
module csf_chk
   import csf_pkg::*;
(
   input wire logic I_REF_CLK,
   input wire logic I_RESET,
   input wire logic i_exec,
   input wire csf_op_t i_op,
   input wire logic i_wr_en,
   input wire logic [7:0] i_wr_addr,
   input wire logic i_wdog_clear,
   input wire logic i_sleep,
   input wire logic i_wdog_expire,
   input wire logic [7:0] o_status,
   input wire logic o_bank_select_bit,
   input wire logic [7:0] o_direct_full_addr
);
   default clocking @(posedge I_REF_CLK); endclocking
   default disable iff (I_RESET);
   sequence clr_req;
      i_exec && i_wr_en && i_op == CSF_OP_CLEAR && (i_wr_addr == CSF_ADDR_LO || i_wr_addr == CSF_ADDR_HI);
   endsequence
   sequence quiet4;
      !(i_wdog_clear || i_sleep || i_wdog_expire) [*4];
   endsequence
   rst_val_a: assert property ($fell(I_RESET) |-> o_status == 8'h18)
      else $error("status not 18h after reset");
   wdx_expire_a: assert property (i_wdog_expire |-> ##[2:3] !o_status[4])
      else $error("expiry did not clear bit 4");
   wdx_set_a: assert property ((i_wdog_clear || i_sleep) && !i_wdog_expire |-> ##[2:3] o_status[4])
      else $error("bit 4 not set");
   slp_clr_a: assert property (i_sleep |-> ##[2:3] !o_status[3])
      else $error("sleep did not clear bit 3");
   slp_set_a: assert property (i_wdog_clear && !i_sleep |-> ##[2:3] o_status[3])
      else $error("bit 3 not set");
   prot_bits_a: assert property (quiet4 |-> $stable(o_status[4:3]))
      else $error("bits 4:3 moved without event");
   bank_route_a: assert property (o_bank_select_bit == o_status[5] && o_direct_full_addr[7] == o_status[5])
      else $error("bank select mismatch");
   clr_file_a: assert property (clr_req |-> ##[2:3] (o_status[7:5] == 3'h0 && o_status[2]))
      else $error("clear of status wrong");
endmodule
bind csf_status_reg csf_chk chk (.*);
`default_nettype wire

// ---- tb/cpu_status_flags_register_test.sv ----
/* Bench for csf_status_reg: all ops, both status addresses, events.
   Assumes result visible within three edges of a request. */
`timescale 1ns/1ns
`default_nettype none
module cpu_status_flags_register_test
   import csf_pkg::*;
();
   logic clk = 1'b0, rst = 1'b1, ex = 1'b0, we = 1'b0, wc = 1'b0, sl = 1'b0, wx = 1'b0, bk_o;
   logic [7:0] a = 8'h0, b = 8'h0, rs = 8'h0, res = 8'h0, wa = 8'h0, wd = 8'h0, st_o, fa_o, m = 8'h18;
   logic [6:0] da = 7'h0;
   csf_op_t op = CSF_OP_NONE;
   int mismatches = 0, cmp_count = 0;
   integer seed = 32'h13f9ddb9;
   logic [7:0] exp_q[$];
   event chk_ev;
   always #50 clk = ~clk;
   csf_status_reg uut (.I_REF_CLK(clk), .I_RESET(rst), .i_exec(ex), .i_op(op), .i_opnd_a(a), .i_opnd_b(b),
      .i_rot_src(rs), .i_result(res), .i_wr_en(we), .i_wr_addr(wa), .i_wr_data(wd), .i_wdog_clear(wc),
      .i_sleep(sl), .i_wdog_expire(wx), .i_direct_addr(da), .o_status(st_o), .o_bank_select_bit(bk_o),
      .o_direct_full_addr(fa_o));
   task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] expv);
      cmp_count++;
      if (seen !== expv) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", nm, expv, seen);
      end
   endtask
   task automatic close_out();
      $display("compares %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic settle();
      repeat (3) @(posedge clk);
      @(negedge clk);
      exp_q.push_back(m);
      -> chk_ev;
   endtask
   always @(chk_ev) begin
      check("status", st_o, exp_q.pop_front());
      check("bank", {7'h0, bk_o}, {7'h0, m[5]});
      check("addr", fa_o, {m[5], da});
   end
   task automatic instr(input csf_op_t o, input logic w, input logic [7:0] adr);
      logic [8:0] s;
      logic [4:0] n;
      logic [7:0] bb;
      logic sub;
      @(negedge clk);
      {a, b, rs, wd, da} = 39'({$random(seed), $random(seed)});
      wd = (o == CSF_OP_CLEAR) ? 8'h00 : wd & 8'h3f;
      sub = o == CSF_OP_SUB;
      if (rs[1:0] == 2'h0) b = sub ? a : -a;
      bb = sub ? ~b : b;
      s = {1'b0, a} + {1'b0, bb} + 9'(sub);
      n = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + 5'(sub);
      res = (o == CSF_OP_ADD || sub) ? s[7:0] : (o == CSF_OP_CLEAR ? 8'h0 : a & b);
      op = o;
      {we, wa, ex} = {w, adr, 1'b1};
      @(negedge clk);
      {ex, we} = 2'h0;
      if (w && (adr == CSF_ADDR_LO || adr == CSF_ADDR_HI)) m = {wd[7:5], m[4:3], (o == CSF_OP_NONE) ? wd[2:0] : m[2:0]};
      case (o)
         CSF_OP_ADD, CSF_OP_SUB: m[2:0] = {s[7:0] == 8'h0, n[4], s[8]};
         CSF_OP_LOGIC: m[2] = res == 8'h0;
         CSF_OP_CLEAR: m[2] = 1'b1;
         CSF_OP_ROR: m[0] = rs[0];
         CSF_OP_ROL: m[0] = rs[7];
         default: ;
      endcase
      settle();
   endtask
   task automatic evt(input logic c, input logic p, input logic x);
      @(negedge clk);
      {wc, sl, wx} = {c, p, x};
      @(negedge clk);
      {wc, sl, wx} = 3'h0;
      m[4:3] = {~x & (m[4] | c | p), ~p & (m[3] | c)};
      settle();
   endtask
   initial begin
      repeat (6) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      settle();
      // Address bits walk status low, status high and an ordinary file
      for (int i = 0; i < 84; i++) begin
         instr(csf_op_t'(i % 7), i[0], i[1] ? CSF_ADDR_HI : (i[2] ? CSF_ADDR_LO : 8'h40));
         if (i % 12 == 5) evt(i[3], i[4], i[5]);
      end
      @(posedge clk);
      close_out();
   end
   initial begin
      #200000;
      mismatches++;
      close_out();
   end
endmodule
`default_nettype wire
